// File: hdl/dio_consts.svh
// Register offsets, field positions and reset values of the digital I/O block
`ifndef DIO_CONSTS_SVH
`define DIO_CONSTS_SVH

`define OFF_DIR_MAIN    8'h00
`define OFF_DIR_AUX     8'h04
`define OFF_OUT_MAIN    8'h08
`define OFF_OUT_AUX     8'h0c
`define OFF_WSEL_MAIN   8'h10
`define OFF_IN_MAIN     8'h14
`define OFF_IN_AUX      8'h18
`define OFF_CLK_CFG     8'h1c
`define OFF_FIFO_DATA   8'h20
`define OFF_FIFO_STAT   8'h24
`define OFF_RISE_MAIN   8'h28
`define OFF_FALL_MAIN   8'h2c
`define OFF_RISE_AUX    8'h30
`define OFF_FALL_AUX    8'h34
`define OFF_PFI_ROUTE   8'h38
`define OFF_PFI_STATIC  8'h3c
`define OFF_IRQ_STAT    8'h40
`define OFF_IRQ_MASK    8'h44
`define OFF_PU_DIR_MAIN 8'h48
`define OFF_PU_VAL_MAIN 8'h4c
`define OFF_PU_DIR_AUX  8'h50
`define OFF_PU_VAL_AUX  8'h54
`define OFF_CMD         8'h58
`define OFF_EVT_ROUTE   8'h5c

`define CFG_SRC_LSB     0
`define CFG_SRC_MSB     5
`define CFG_POL         6
`define CFG_RETX        7
`define CFG_RUN         8

`define CMD_APPLY       0
`define CMD_CLEAR       1

`define IRQ_UNDER       0
`define IRQ_OVER        1
`define IRQ_CHG         2
`define IRQ_W           3

`define FST_EMPTY       16
`define FST_FULL        17

`define ROUTE_PXI       8

`define FETCH_LAT       2'h1
`define RST_WORD        32'h0000_0000

`endif

// File: hdl/dio_pkg.sv
// Shared types of the digital I/O block
package dio_pkg;
    typedef logic [31:0] word_t;
    typedef logic [7:0]  addr_t;
endpackage

// File: hdl/wave_mem_if.sv
// Carrier between waveform sample control and its storage
`timescale 1ns/1ps
`default_nettype none
interface wave_mem_if #(
    parameter int AW = 4,
    parameter int DW = 32
);
    logic          wr_en;
    logic [AW-1:0] wr_addr;
    logic [DW-1:0] wr_data;
    logic [AW-1:0] rd_addr;
    logic [DW-1:0] rd_data;

    modport ctl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface
`default_nettype wire

// File: hdl/wave_mem.sv
// Waveform sample storage with registered read data
`timescale 1ns/1ps
`default_nettype none
module wave_mem #(
    parameter int AW = 4,
    parameter int DW = 32
) (
    // Clock
    input wire logic clk,
    // Storage port
    wave_mem_if.mem  port
);
    logic [DW-1:0] mem_q [0:(1<<AW)-1];
    logic [DW-1:0] rd_ff;

    always_ff @(posedge clk) begin
        if (port.wr_en) begin
            mem_q[port.wr_addr] <= port.wr_data;
        end
        rd_ff <= mem_q[port.rd_addr];
    end

    assign port.rd_data = rd_ff;
endmodule
`default_nettype wire

// File: hdl/dio_wave_change.sv
// Digital I/O lines with waveform output, sample clock routing and change detection
//
// Operation
// - Active sample clock edge with empty sample store flags underflow.
// - Sample clock picks internal analog, counter, frequency or change sources, with polarity.
// - Sample clock also picks function lines, trigger bus, star line or comparator.
// - Samples update on rising or falling clock edge as configured.
// - Edges too close for the next sample flag overrun.
// - Sample clock routes inverted to any function line.
// - Reset leaves every line and function line undriven.
// - Each line has a programmable power-up state: undriven, drive 0, drive 1.
// - Each line detects rising, falling or both edges independently.
// - Inputs are synchronised to the block clock before detection.
// - Change event is the OR of all enabled detectors.
// - Change event drives trigger bus, function lines, star line, clock, interrupt.
// - Detection also sees values driven on output lines.
// - Each of 32 main and two 8-line ports has its own direction.
// - Each active edge that flags neither underflow nor overrun moves the next sample onto waveform lines.
// - Retransmit mode replays stored samples from the first, in order.
// - Sample clock is never divided from a timebase, only routed.
`timescale 1ns/1ps
`default_nettype none
`include "dio_consts.svh"
module dio_wave_change
    import dio_pkg::*;
#(
    parameter int MAIN_N   = 32,
    parameter int SECOND_N = 8,
    parameter int THIRD_N  = 8,
    parameter int PFI_N    = 16,
    parameter int TRIG_N   = 8,
    parameter int CTR_N    = 2,
    parameter int DEPTH    = 16
) (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst_n,
    // Register port
    input  wire logic [7:0]          reg_addr,
    input  wire logic [31:0]         reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic [31:0]              reg_rdata,
    // Internal clock sources
    input  wire logic                analog_in_sample_clock,
    input  wire logic                analog_in_convert_clock,
    input  wire logic                analog_out_sample_clock,
    input  wire logic [CTR_N-1:0]    counter_internal_out,
    input  wire logic                frequency_output,
    input  wire logic                analog_compare_event,
    // Main port
    input  wire logic [MAIN_N-1:0]   main_port_lines_in,
    output logic [MAIN_N-1:0]        main_port_lines_out,
    output logic [MAIN_N-1:0]        main_port_lines_oe,
    // Second port
    input  wire logic [SECOND_N-1:0] second_port_lines_in,
    output logic [SECOND_N-1:0]      second_port_lines_out,
    output logic [SECOND_N-1:0]      second_port_lines_oe,
    // Third port
    input  wire logic [THIRD_N-1:0]  third_port_lines_in,
    output logic [THIRD_N-1:0]       third_port_lines_out,
    output logic [THIRD_N-1:0]       third_port_lines_oe,
    // Function lines
    input  wire logic [PFI_N-1:0]    programmable_function_lines_in,
    output logic [PFI_N-1:0]         programmable_function_lines_out,
    output logic [PFI_N-1:0]         programmable_function_lines_oe,
    // Trigger bus and star line
    input  wire logic [TRIG_N-1:0]   trigger_bus_lines_in,
    output logic [TRIG_N-1:0]        trigger_bus_lines_out,
    output logic [TRIG_N-1:0]        trigger_bus_lines_oe,
    input  wire logic                pxi_star_in,
    output logic                     pxi_star_out,
    output logic                     pxi_star_oe,
    // Change event and interrupt
    output logic                     change_event,
    output logic                     irq
);
    localparam int AUX_N = SECOND_N + THIRD_N;
    localparam int LN    = MAIN_N + AUX_N;
    localparam int SW    = LN + PFI_N + TRIG_N + 1;
    localparam int AW    = $clog2(DEPTH);
    localparam int CW    = AW + 1;
    localparam int SRC_N = 64;

    function automatic logic hit(input addr_t a, input addr_t off);
        return a == off;
    endfunction

    // Register decode
    logic wr_dir_main, wr_dir_aux, wr_out_main, wr_out_aux, wr_wsel, wr_cfg;
    logic wr_fifo, wr_rise_main, wr_fall_main, wr_rise_aux, wr_fall_aux;
    logic wr_pfi_route, wr_pfi_static, wr_mask, wr_pu_dm, wr_pu_vm, wr_pu_da, wr_pu_va;
    logic wr_cmd, wr_evt_route, rd_stat, apply_pu, fifo_clear;

    assign wr_dir_main   = reg_wr & hit(reg_addr, `OFF_DIR_MAIN);
    assign wr_dir_aux    = reg_wr & hit(reg_addr, `OFF_DIR_AUX);
    assign wr_out_main   = reg_wr & hit(reg_addr, `OFF_OUT_MAIN);
    assign wr_out_aux    = reg_wr & hit(reg_addr, `OFF_OUT_AUX);
    assign wr_wsel       = reg_wr & hit(reg_addr, `OFF_WSEL_MAIN);
    assign wr_cfg        = reg_wr & hit(reg_addr, `OFF_CLK_CFG);
    assign wr_fifo       = reg_wr & hit(reg_addr, `OFF_FIFO_DATA);
    assign wr_rise_main  = reg_wr & hit(reg_addr, `OFF_RISE_MAIN);
    assign wr_fall_main  = reg_wr & hit(reg_addr, `OFF_FALL_MAIN);
    assign wr_rise_aux   = reg_wr & hit(reg_addr, `OFF_RISE_AUX);
    assign wr_fall_aux   = reg_wr & hit(reg_addr, `OFF_FALL_AUX);
    assign wr_pfi_route  = reg_wr & hit(reg_addr, `OFF_PFI_ROUTE);
    assign wr_pfi_static = reg_wr & hit(reg_addr, `OFF_PFI_STATIC);
    assign wr_mask       = reg_wr & hit(reg_addr, `OFF_IRQ_MASK);
    assign wr_pu_dm      = reg_wr & hit(reg_addr, `OFF_PU_DIR_MAIN);
    assign wr_pu_vm      = reg_wr & hit(reg_addr, `OFF_PU_VAL_MAIN);
    assign wr_pu_da      = reg_wr & hit(reg_addr, `OFF_PU_DIR_AUX);
    assign wr_pu_va      = reg_wr & hit(reg_addr, `OFF_PU_VAL_AUX);
    assign wr_cmd        = reg_wr & hit(reg_addr, `OFF_CMD);
    assign wr_evt_route  = reg_wr & hit(reg_addr, `OFF_EVT_ROUTE);
    assign rd_stat       = reg_rd & hit(reg_addr, `OFF_IRQ_STAT);
    assign apply_pu      = wr_cmd & reg_wdata[`CMD_APPLY];
    assign fifo_clear    = wr_cmd & reg_wdata[`CMD_CLEAR];

    // Configuration registers
    logic [MAIN_N-1:0] dir_main_ff, out_main_ff, wsel_ff, rise_main_ff, fall_main_ff;
    logic [MAIN_N-1:0] pu_dir_main_ff, pu_val_main_ff;
    logic [AUX_N-1:0]  dir_aux_ff, out_aux_ff, rise_aux_ff, fall_aux_ff;
    logic [AUX_N-1:0]  pu_dir_aux_ff, pu_val_aux_ff;
    word_t             cfg_ff, pfi_route_ff, pfi_static_ff, evt_route_ff;
    logic [`IRQ_W-1:0] mask_ff;

    // Direction and static value, with power-up load
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dir_main_ff <= '0;
            dir_aux_ff  <= '0;
            out_main_ff <= '0;
            out_aux_ff  <= '0;
        end else if (apply_pu) begin
            dir_main_ff <= pu_dir_main_ff;
            dir_aux_ff  <= pu_dir_aux_ff;
            out_main_ff <= pu_val_main_ff;
            out_aux_ff  <= pu_val_aux_ff;
        end else begin
            if (wr_dir_main) dir_main_ff <= reg_wdata[MAIN_N-1:0];
            if (wr_dir_aux)  dir_aux_ff  <= reg_wdata[AUX_N-1:0];
            if (wr_out_main) out_main_ff <= reg_wdata[MAIN_N-1:0];
            if (wr_out_aux)  out_aux_ff  <= reg_wdata[AUX_N-1:0];
        end
    end

    // Power-up state store, undriven by default
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pu_dir_main_ff <= '0;
            pu_val_main_ff <= '0;
            pu_dir_aux_ff  <= '0;
            pu_val_aux_ff  <= '0;
        end else begin
            if (wr_pu_dm) pu_dir_main_ff <= reg_wdata[MAIN_N-1:0];
            if (wr_pu_vm) pu_val_main_ff <= reg_wdata[MAIN_N-1:0];
            if (wr_pu_da) pu_dir_aux_ff  <= reg_wdata[AUX_N-1:0];
            if (wr_pu_va) pu_val_aux_ff  <= reg_wdata[AUX_N-1:0];
        end
    end

    // Detector enables and routing
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wsel_ff       <= '0;
            rise_main_ff  <= '0;
            fall_main_ff  <= '0;
            rise_aux_ff   <= '0;
            fall_aux_ff   <= '0;
            cfg_ff        <= `RST_WORD;
            pfi_route_ff  <= `RST_WORD;
            pfi_static_ff <= `RST_WORD;
            evt_route_ff  <= `RST_WORD;
            mask_ff       <= '0;
        end else begin
            if (wr_wsel)       wsel_ff       <= reg_wdata[MAIN_N-1:0];
            if (wr_rise_main)  rise_main_ff  <= reg_wdata[MAIN_N-1:0];
            if (wr_fall_main)  fall_main_ff  <= reg_wdata[MAIN_N-1:0];
            if (wr_rise_aux)   rise_aux_ff   <= reg_wdata[AUX_N-1:0];
            if (wr_fall_aux)   fall_aux_ff   <= reg_wdata[AUX_N-1:0];
            if (wr_cfg)        cfg_ff        <= reg_wdata;
            if (wr_pfi_route)  pfi_route_ff  <= reg_wdata;
            if (wr_pfi_static) pfi_static_ff <= reg_wdata;
            if (wr_evt_route)  evt_route_ff  <= reg_wdata;
            if (wr_mask)       mask_ff       <= reg_wdata[`IRQ_W-1:0];
        end
    end

    // Three-stage input synchroniser, value taken once stages two and three agree
    logic [SW-1:0] ext_raw, s1_ff, s2_ff, s3_ff, filt_ff, agree;
    assign ext_raw = {pxi_star_in, trigger_bus_lines_in, programmable_function_lines_in,
                      third_port_lines_in, second_port_lines_in, main_port_lines_in};
    assign agree   = ~(s2_ff ^ s3_ff);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_ff   <= '0;
            s2_ff   <= '0;
            s3_ff   <= '0;
            filt_ff <= '0;
        end else begin
            s1_ff   <= ext_raw;
            s2_ff   <= s1_ff;
            s3_ff   <= s2_ff;
            filt_ff <= (s3_ff & agree) | (filt_ff & ~agree);
        end
    end

    logic [MAIN_N-1:0] main_in;
    logic [AUX_N-1:0]  aux_in;
    logic [PFI_N-1:0]  pfi_in;
    logic [TRIG_N-1:0] trig_in;
    logic              pxi_in;
    assign main_in = filt_ff[MAIN_N-1:0];
    assign aux_in  = filt_ff[MAIN_N +: AUX_N];
    assign pfi_in  = filt_ff[LN +: PFI_N];
    assign trig_in = filt_ff[LN + PFI_N +: TRIG_N];
    assign pxi_in  = filt_ff[SW-1];

    // Change detection per line
    logic [LN-1:0] line_dir, line_drv, line_in, cd_cur, cd_prev_ff, rise_en, fall_en, cd_hit;
    logic          chg_ev_ff;
    logic [MAIN_N-1:0] main_drv_ff;
    assign line_dir = {dir_aux_ff, dir_main_ff};
    assign line_drv = {out_aux_ff, main_drv_ff};
    assign line_in  = {aux_in, main_in};
    assign cd_cur   = (line_dir & line_drv) | (~line_dir & line_in);
    assign rise_en  = {rise_aux_ff, rise_main_ff};
    assign fall_en  = {fall_aux_ff, fall_main_ff};

    genvar gi;
    generate
        for (gi = 0; gi < LN; gi++) begin : g_det
            assign cd_hit[gi] = (rise_en[gi] & cd_cur[gi] & ~cd_prev_ff[gi])
                              | (fall_en[gi] & ~cd_cur[gi] & cd_prev_ff[gi]);
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cd_prev_ff <= '0;
            chg_ev_ff  <= 1'b0;
        end else begin
            cd_prev_ff <= cd_cur;
            chg_ev_ff  <= |cd_hit;
        end
    end

    // Sample clock source select and active edge, routed only
    logic [SRC_N-1:0] src_vec;
    logic [5:0]       src_sel;
    logic             src_lvl, clk_lvl, clk_prev_ff, act_edge;
    assign src_vec = {{(SRC_N-PFI_N-32){1'b0}}, pfi_in, {(16-TRIG_N){1'b0}}, trig_in,
                      {(16-9){1'b0}}, analog_compare_event, pxi_in, chg_ev_ff,
                      frequency_output, counter_internal_out[CTR_N-1:0],
                      analog_out_sample_clock, analog_in_convert_clock,
                      analog_in_sample_clock};
    assign src_sel  = cfg_ff[`CFG_SRC_MSB:`CFG_SRC_LSB];
    assign src_lvl  = src_vec[src_sel];
    assign clk_lvl  = src_lvl ^ cfg_ff[`CFG_POL];
    assign act_edge = cfg_ff[`CFG_RUN] & clk_lvl & ~clk_prev_ff;

    // Waveform sample store control
    wave_mem_if #(.AW(AW), .DW(MAIN_N)) mem_bus ();
    logic [AW-1:0] head_ff, tail_ff, cur_ff, nxt_cur;
    logic [CW-1:0] cnt_ff, pos_ff, nxt_pos;
    logic [1:0]    busy_ff;
    logic [MAIN_N-1:0] wave_ff;
    logic          fifo_empty, fifo_full, push, take, pop, underflow, overrun, wrap;

    assign fifo_empty = (cnt_ff == '0);
    assign fifo_full  = (cnt_ff == CW'(DEPTH));
    assign push       = wr_fifo & ~fifo_full;
    assign underflow  = act_edge & fifo_empty;
    assign overrun    = act_edge & ~fifo_empty & (busy_ff != 2'h0);
    assign take       = act_edge & ~fifo_empty & (busy_ff == 2'h0);
    assign pop        = take & ~cfg_ff[`CFG_RETX];
    assign wrap       = (pos_ff == cnt_ff - CW'(1));
    assign nxt_cur    = ~cfg_ff[`CFG_RETX] ? (pop ? head_ff + AW'(1) : head_ff)
                      : (take ? (wrap ? head_ff : cur_ff + AW'(1)) : cur_ff);
    assign nxt_pos    = (take & cfg_ff[`CFG_RETX]) ? (wrap ? '0 : pos_ff + CW'(1)) : pos_ff;

    assign mem_bus.wr_en   = push;
    assign mem_bus.wr_addr = tail_ff;
    assign mem_bus.wr_data = reg_wdata[MAIN_N-1:0];
    assign mem_bus.rd_addr = cur_ff;

    wave_mem #(.AW(AW), .DW(MAIN_N)) u_mem (
        .clk  (clk),
        .port (mem_bus.mem)
    );

    always_ff @(posedge clk) begin
        if (!rst_n || fifo_clear) begin
            head_ff <= '0;
            tail_ff <= '0;
            cur_ff  <= '0;
            cnt_ff  <= '0;
            pos_ff  <= '0;
            busy_ff <= 2'h0;
        end else begin
            head_ff <= pop ? head_ff + AW'(1) : head_ff;
            tail_ff <= push ? tail_ff + AW'(1) : tail_ff;
            cur_ff  <= nxt_cur;
            pos_ff  <= nxt_pos;
            cnt_ff  <= cnt_ff + CW'(push) - CW'(pop);
            busy_ff <= (take || (push && fifo_empty)) ? `FETCH_LAT
                     : (busy_ff != 2'h0 ? busy_ff - 2'h1 : 2'h0);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            clk_prev_ff <= 1'b0;
            wave_ff     <= '0;
        end else begin
            clk_prev_ff <= clk_lvl;
            if (take) wave_ff <= mem_bus.rd_data;
        end
    end

    // Interrupt status, set wins over read clear
    logic [`IRQ_W-1:0] stat_ff, stat_set;
    logic              irq_ff;
    assign stat_set[`IRQ_UNDER] = underflow;
    assign stat_set[`IRQ_OVER]  = overrun;
    assign stat_set[`IRQ_CHG]   = chg_ev_ff;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stat_ff <= '0;
            irq_ff  <= 1'b0;
        end else begin
            stat_ff <= (stat_ff & ~{`IRQ_W{rd_stat}}) | stat_set;
            irq_ff  <= |(stat_ff & mask_ff);
        end
    end

    // Pin drivers, undriven from reset
    logic [PFI_N-1:0] pfi_clk_rt, pfi_evt_rt, pfi_st_oe, pfi_st_val;
    logic [PFI_N-1:0] pfi_out_ff, pfi_oe_ff;
    logic [MAIN_N-1:0] main_oe_ff;
    logic [AUX_N-1:0]  aux_out_ff, aux_oe_ff;
    logic [TRIG_N-1:0] trig_out_ff, trig_oe_ff;
    logic              pxi_out_ff, pxi_oe_ff;
    assign pfi_clk_rt = pfi_route_ff[PFI_N-1:0];
    assign pfi_evt_rt = pfi_route_ff[2*PFI_N-1:PFI_N];
    assign pfi_st_oe  = pfi_static_ff[PFI_N-1:0];
    assign pfi_st_val = pfi_static_ff[2*PFI_N-1:PFI_N];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            main_drv_ff <= '0;
            main_oe_ff  <= '0;
            aux_out_ff  <= '0;
            aux_oe_ff   <= '0;
            pfi_out_ff  <= '0;
            pfi_oe_ff   <= '0;
            trig_out_ff <= '0;
            trig_oe_ff  <= '0;
            pxi_out_ff  <= 1'b0;
            pxi_oe_ff   <= 1'b0;
        end else begin
            main_drv_ff <= (wsel_ff & wave_ff) | (~wsel_ff & out_main_ff);
            main_oe_ff  <= dir_main_ff;
            aux_out_ff  <= out_aux_ff;
            aux_oe_ff   <= dir_aux_ff;
            pfi_out_ff  <= (pfi_clk_rt & {PFI_N{~clk_lvl}})
                         | (~pfi_clk_rt & pfi_evt_rt & {PFI_N{chg_ev_ff}})
                         | (~pfi_clk_rt & ~pfi_evt_rt & pfi_st_val);
            pfi_oe_ff   <= pfi_clk_rt | pfi_evt_rt | pfi_st_oe;
            trig_out_ff <= evt_route_ff[TRIG_N-1:0] & {TRIG_N{chg_ev_ff}};
            trig_oe_ff  <= evt_route_ff[TRIG_N-1:0];
            pxi_out_ff  <= evt_route_ff[`ROUTE_PXI] & chg_ev_ff;
            pxi_oe_ff   <= evt_route_ff[`ROUTE_PXI];
        end
    end

    // Read-back
    word_t rd_mux, rdata_ff, fifo_stat;
    always_comb begin
        fifo_stat             = `RST_WORD;
        fifo_stat[CW-1:0]     = cnt_ff;
        fifo_stat[`FST_EMPTY] = fifo_empty;
        fifo_stat[`FST_FULL]  = fifo_full;
        unique case (reg_addr)
            `OFF_DIR_MAIN:    rd_mux = 32'(dir_main_ff);
            `OFF_DIR_AUX:     rd_mux = 32'(dir_aux_ff);
            `OFF_OUT_MAIN:    rd_mux = 32'(out_main_ff);
            `OFF_OUT_AUX:     rd_mux = 32'(out_aux_ff);
            `OFF_WSEL_MAIN:   rd_mux = 32'(wsel_ff);
            `OFF_IN_MAIN:     rd_mux = 32'(main_in);
            `OFF_IN_AUX:      rd_mux = 32'(aux_in);
            `OFF_CLK_CFG:     rd_mux = cfg_ff;
            `OFF_FIFO_STAT:   rd_mux = fifo_stat;
            `OFF_RISE_MAIN:   rd_mux = 32'(rise_main_ff);
            `OFF_FALL_MAIN:   rd_mux = 32'(fall_main_ff);
            `OFF_RISE_AUX:    rd_mux = 32'(rise_aux_ff);
            `OFF_FALL_AUX:    rd_mux = 32'(fall_aux_ff);
            `OFF_PFI_ROUTE:   rd_mux = pfi_route_ff;
            `OFF_PFI_STATIC:  rd_mux = pfi_static_ff;
            `OFF_IRQ_STAT:    rd_mux = 32'(stat_ff);
            `OFF_IRQ_MASK:    rd_mux = 32'(mask_ff);
            `OFF_PU_DIR_MAIN: rd_mux = 32'(pu_dir_main_ff);
            `OFF_PU_VAL_MAIN: rd_mux = 32'(pu_val_main_ff);
            `OFF_PU_DIR_AUX:  rd_mux = 32'(pu_dir_aux_ff);
            `OFF_PU_VAL_AUX:  rd_mux = 32'(pu_val_aux_ff);
            `OFF_EVT_ROUTE:   rd_mux = evt_route_ff;
            default:          rd_mux = `RST_WORD;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_ff <= `RST_WORD;
        end else begin
            rdata_ff <= reg_rd ? rd_mux : `RST_WORD;
        end
    end

    // Outputs
    assign reg_rdata                       = rdata_ff;
    assign main_port_lines_out             = main_drv_ff;
    assign main_port_lines_oe              = main_oe_ff;
    assign second_port_lines_out           = aux_out_ff[SECOND_N-1:0];
    assign second_port_lines_oe            = aux_oe_ff[SECOND_N-1:0];
    assign third_port_lines_out            = aux_out_ff[AUX_N-1:SECOND_N];
    assign third_port_lines_oe             = aux_oe_ff[AUX_N-1:SECOND_N];
    assign programmable_function_lines_out = pfi_out_ff;
    assign programmable_function_lines_oe  = pfi_oe_ff;
    assign trigger_bus_lines_out           = trig_out_ff;
    assign trigger_bus_lines_oe            = trig_oe_ff;
    assign pxi_star_out                    = pxi_out_ff;
    assign pxi_star_oe                     = pxi_oe_ff;
    assign change_event                    = chg_ev_ff;
    assign irq                             = irq_ff;
endmodule
`default_nettype wire

// File: tb/dio_monitor.sv
// Port checker for the digital I/O block
`timescale 1ns/1ps
`default_nettype none
`include "dio_consts.svh"
module dio_monitor #(parameter int MAIN_N = 32, parameter int PFI_N = 16) (
    // Clock, reset and register port
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic [7:0]        reg_addr,
    input wire logic [31:0]       reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [31:0]       reg_rdata,
    // Lines and interrupt
    input wire logic [MAIN_N-1:0] main_port_lines_in,
    input wire logic [MAIN_N-1:0] main_port_lines_oe,
    input wire logic [PFI_N-1:0]  programmable_function_lines_oe,
    input wire logic              irq
);
    wire logic stat_rd = reg_rd && reg_addr == `OFF_IRQ_STAT;
    wire logic mask_wr = reg_wr && reg_addr == `OFF_IRQ_MASK;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence in_steady;
        $stable(main_port_lines_in) [*6];
    endsequence
    chk_reset_undriven: assert property (
        $rose(rst_n) |-> !(|main_port_lines_oe) && !(|programmable_function_lines_oe))
        else $error("lines driven after reset");
    chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data outside read slot");
    chk_dir_write: assert property (
        reg_wr && reg_addr == `OFF_DIR_MAIN |=> ##1 main_port_lines_oe == $past(reg_wdata, 2))
        else $error("direction write not applied");
    chk_dir_readback: assert property (
        reg_rd && reg_addr == `OFF_DIR_MAIN |=> reg_rdata == main_port_lines_oe)
        else $error("readback differs");
    chk_flag_hold: assert property (
        $fell(irq) |-> $past(stat_rd, 2) || $past(mask_wr, 2))
        else $error("irq dropped");
    chk_fifo_flags: assert property (
        reg_rd && reg_addr == `OFF_FIFO_STAT |=> reg_rdata[`FST_EMPTY] == (reg_rdata[4:0] == 5'h0)
        && !(reg_rdata[`FST_EMPTY] && reg_rdata[`FST_FULL])) else $error("fifo flags wrong");
    chk_input_sync: assert property (
        in_steady ##0 (reg_rd && reg_addr == `OFF_IN_MAIN) |=> reg_rdata == $past(main_port_lines_in))
        else $error("filtered input wrong");
    chk_cmd_zero: assert property (
        reg_rd && (reg_addr == `OFF_CMD || reg_addr > `OFF_EVT_ROUTE) |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
endmodule
bind dio_wave_change dio_monitor #(.MAIN_N(MAIN_N), .PFI_N(PFI_N)) mon (.clk, .rst_n,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .main_port_lines_in,
    .main_port_lines_oe, .programmable_function_lines_oe, .irq);
`default_nettype wire

// File: tb/line_partner.sv
// External circuits on the main port lines
`timescale 1ns/1ps
`default_nettype none
module line_partner (
    // Device and bench drive
    input  wire logic [31:0] dev_out,
    input  wire logic [31:0] dev_oe,
    input  wire logic [31:0] ext_val,
    // Resolved level, released device lines follow the outside circuit
    output logic      [31:0] pin
);
    assign pin = (dev_oe & dev_out) | (~dev_oe & ext_val);
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the digital I/O block
`timescale 1ns/1ps
`default_nettype none
`include "dio_consts.svh"
module tb_top import dio_pkg::*; ;
    logic clk, rst_n, reg_wr, reg_rd, irq;
    addr_t reg_addr;
    word_t reg_wdata, reg_rdata, main_out, main_oe, pin, ext_val;
    logic [6:0] src;
    logic [15:0] aux;
    int err_total, cmp_count;
    line_partner lp (.dev_out(main_out), .dev_oe(main_oe), .ext_val(ext_val), .pin(pin));
    dio_wave_change dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .analog_in_sample_clock(src[0]), .analog_in_convert_clock(src[1]),
        .analog_out_sample_clock(src[2]), .counter_internal_out(src[4:3]),
        .frequency_output(src[5]), .analog_compare_event(src[6]), .main_port_lines_in(pin),
        .main_port_lines_out(main_out), .main_port_lines_oe(main_oe),
        .second_port_lines_in(aux[7:0]), .second_port_lines_out(), .second_port_lines_oe(),
        .third_port_lines_in(aux[15:8]), .third_port_lines_out(), .third_port_lines_oe(),
        .programmable_function_lines_in(16'h0000), .programmable_function_lines_out(),
        .programmable_function_lines_oe(), .trigger_bus_lines_in(8'h00),
        .trigger_bus_lines_out(), .trigger_bus_lines_oe(), .pxi_star_in(1'b0),
        .pxi_star_out(), .pxi_star_oe(), .change_event(), .irq);
    task automatic end_of_test();
        $display("Compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input word_t got, input word_t exp);
        cmp_count++;
        if (got !== exp) begin
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
            err_total++;
        end
    endtask
    task automatic wr(input addr_t a, input word_t d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input addr_t a, input word_t exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
        @(posedge clk);
    endtask
    task automatic wait_irq();
        for (int n = 0; n < 20 && irq !== 1'b1; n++) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        if (irq !== 1'b1) end_of_test();
    endtask
    task automatic s_change();
        wr(`OFF_DIR_MAIN, 32'hffff_ff00);
        rd(`OFF_DIR_MAIN, 32'hffff_ff00);
        wr(`OFF_IRQ_MASK, 32'h0000_0004);
        wr(`OFF_RISE_MAIN, 32'h0000_0108);
        ext_val <= 32'h0000_0008;
        wait_irq();
        rd(`OFF_IRQ_STAT, 32'h0000_0004);
        wr(`OFF_OUT_MAIN, 32'h0000_0100);
        wait_irq();
        rd(`OFF_IRQ_STAT, 32'h0000_0004);
        rd(`OFF_IN_MAIN, 32'h0000_0108);
    endtask
    task automatic s_wave();
        wr(`OFF_WSEL_MAIN, 32'hffff_0000);
        wr(`OFF_FIFO_DATA, 32'h5a5a_0000);
        wr(`OFF_CLK_CFG, 32'h0000_0100);
        for (int k = 0; k < 2; k++) begin
            src[0] <= 1'b1;
            repeat (2) @(posedge clk);
            src[0] <= 1'b0;
            repeat (8) @(posedge clk);
        end
        chk(main_out, 32'h5a5a_0100);
        rd(`OFF_IRQ_STAT, 32'h0000_0001);
        rd(`OFF_FIFO_STAT, 32'h0001_0000);
        reg_addr <= `OFF_FIFO_DATA;
        reg_wr <= 1'b1;
        @(posedge clk);
        {reg_wr, src[0]} <= 2'b01;
        repeat (2) @(posedge clk);
        rd(`OFF_IRQ_STAT, 32'h0000_0002);
        rd(`OFF_CMD, 32'h0000_0000);
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, src, aux, ext_val} = '0;
        err_total = 0;
        cmp_count = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk(main_oe, 32'h0000_0000);
        s_change();
        s_wave();
        end_of_test();
    end
endmodule
`default_nettype wire
